/* File: cgc_pkg.sv */
/*
  cgc_pkg: constants for the clock generator control block.
  assumes a byte-wide special-function register port from the cpu.
*/
package cgc_pkg;
  localparam logic [19:0] CGC_ADDR_FREQ_SEL   = 20'hF00A8;
  localparam logic [19:0] CGC_ADDR_SPEED_CTRL = 20'hF00F3;
  localparam logic [19:0] CGC_ADDR_PER_EN     = 20'hF00F0;
  localparam logic [19:0] CGC_ADDR_OPT_BYTE   = 20'h000C2;
  localparam int          CGC_ITMR_EN_BIT     = 4;
  localparam logic [7:0]  CGC_SPEED_RST       = 8'h00;
  localparam logic [7:0]  CGC_PER_RST         = 8'h00;
  localparam logic [7:0]  CGC_PER_RSVD_MASK   = 8'h1A;
  localparam logic [4:0]  CGC_OPT_HIGH_ONES   = 5'h1F;
  localparam logic [2:0]  CGC_FREQ_20M        = 3'h1;
  localparam logic [2:0]  CGC_FREQ_1M25       = 3'h5;
  localparam logic [1:0]  CGC_SWITCH_CYCLES   = 2'h3;
  localparam logic [7:0]  CGC_POR_WAIT_CYCLES = 8'h40;
  typedef enum logic [2:0] {
    CGC_RESET_WAIT, CGC_RUN, CGC_SW_OLD, CGC_SW_NEW, CGC_IDLE, CGC_SLEEP
  } cgc_state_e;
endpackage

/* File: cgc_clock_ctrl.sv */
/*
  cgc_clock_ctrl: register file and clock sequencing of the clock generator.
  assumes byte accesses on sfrAddr with one-cycle write and read strobes,
  the option byte presented on a static input, oscillators outside.
*/
// Contract
// - itmr clock gate follows interval timer clock enable bit four.
// - reset clears speed mode control to zero.
// - all three registers take writes only as whole bytes.
// - reset loads frequency select from the option byte field.
// - codes 001 to 101 select 20, 10, 5, 2.5, 1.25 MHz.
// - option byte holds code in bits 2..0, bits 7..3 are ones.
// - switch runs three old cycles then waits three new cycles.
// - fast oscillator starts itself at reset release.
// - slow clock feeds only watchdog and interval timer, never the cpu.
// - slow oscillator runs while watchdog runs or timer enable is one.
// - cpu clock starts from fast oscillator at option frequency.
// - cpu starts only after the reset processing wait.
// - halt from fast oscillator enters clocked idle.
// - peripheral enable zero holds peripheral in reset, blocks writes.
`timescale 1ns/100ps
module cgc_clock_ctrl
  import cgc_pkg::*;
#(
  parameter int unsigned POR_WAIT = CGC_POR_WAIT_CYCLES
)
(
  // clock and reset
  input  wire logic       mclk,
  input  wire logic       rst_n,
  // register port
  input  wire logic [19:0] sfrAddr,
  input  wire logic       sfrWrite,
  input  wire logic       sfrRead,
  input  wire logic [7:0] sfrWdata,
  output logic [7:0]      sfrRdata,
  // option byte and cpu events
  input  wire logic [7:0] optionByte,
  input  wire logic       haltReq,
  input  wire logic       stopReq,
  input  wire logic       wakeReq,
  input  wire logic       watchdogRun,
  // clock controls, cpu start flag and peripheral reset and write enables
  output logic [2:0]      fastOscFreqSel,
  output logic            fastOscEnable,
  output logic            slowOscEnable,
  output logic            itmrClockGate,
  output logic            cpuClockGate,
  output logic            cpuStarted,
  output logic [7:0]      periphResetN,
  output logic [7:0]      periphWriteEn
);
  import cgc_pkg::*;

  typedef struct packed {
    cgc_state_e st;
    logic [7:0] speed;
    logic [2:0] freq;
    logic [2:0] freqPend;
    logic [7:0] per;
    logic [7:0] cnt;
    logic [7:0] rdata;
    logic       loaded;
    logic       fastEn;
    logic       slowEn;
    logic       cpuGate;
    logic       started;
  } cgc_state_s;

  cgc_state_s cur_r;
  cgc_state_s cur_nxt;

  // reset wait counter is eight bits wide
  if (POR_WAIT < 1 || POR_WAIT > 256) begin : g_porWaitChk
    $error("reset wait count out of range");
  end

  function automatic logic freqLegal(input logic [2:0] c);
    return (c >= CGC_FREQ_20M) && (c <= CGC_FREQ_1M25);
  endfunction

  always_comb begin
    cur_nxt = cur_r;
    cur_nxt.rdata = 8'h00;
    if (!cur_r.loaded) begin
      cur_nxt.loaded = 1'b1;
      if (freqLegal(optionByte[2:0])) begin
        cur_nxt.freq = optionByte[2:0];
      end
      cur_nxt.freqPend = cur_nxt.freq;
    end
    if (sfrWrite) begin
      case (sfrAddr)
        CGC_ADDR_SPEED_CTRL: cur_nxt.speed = sfrWdata & (8'h01 << CGC_ITMR_EN_BIT);
        CGC_ADDR_FREQ_SEL: begin
          if (freqLegal(sfrWdata[2:0]) && cur_r.st == CGC_RUN) begin
            cur_nxt.freqPend = sfrWdata[2:0];
            cur_nxt.st = CGC_SW_OLD;
            cur_nxt.cnt = 8'h00;
          end
        end
        CGC_ADDR_PER_EN: cur_nxt.per = sfrWdata & ~CGC_PER_RSVD_MASK;
        default: ;
      endcase
    end
    if (sfrRead) begin
      case (sfrAddr)
        CGC_ADDR_SPEED_CTRL: cur_nxt.rdata = cur_r.speed;
        CGC_ADDR_FREQ_SEL:   cur_nxt.rdata = {5'h00, cur_r.freqPend};
        CGC_ADDR_PER_EN:     cur_nxt.rdata = cur_r.per;
        CGC_ADDR_OPT_BYTE:   cur_nxt.rdata = {CGC_OPT_HIGH_ONES, optionByte[2:0]};
        default:             cur_nxt.rdata = 8'h00;
      endcase
    end
    case (cur_r.st)
      CGC_RESET_WAIT: begin
        cur_nxt.cnt = cur_r.cnt + 8'h01;
        if (cur_r.cnt == 8'(POR_WAIT - 1)) begin
          cur_nxt.st = CGC_RUN;
          cur_nxt.cnt = 8'h00;
        end
      end
      CGC_RUN: begin
        if (haltReq) begin
          cur_nxt.st = CGC_IDLE;
        end else if (stopReq) begin
          cur_nxt.st = CGC_SLEEP;
        end
      end
      CGC_SW_OLD: begin
        cur_nxt.cnt = cur_r.cnt + 8'h01;
        if (cur_r.cnt == {6'h00, CGC_SWITCH_CYCLES} - 8'h01) begin
          cur_nxt.freq = cur_r.freqPend;
          cur_nxt.st = CGC_SW_NEW;
          cur_nxt.cnt = 8'h00;
        end
      end
      CGC_SW_NEW: begin
        cur_nxt.cnt = cur_r.cnt + 8'h01;
        if (cur_r.cnt == {6'h00, CGC_SWITCH_CYCLES} - 8'h01) begin
          cur_nxt.st = CGC_RUN;
          cur_nxt.cnt = 8'h00;
        end
      end
      CGC_IDLE, CGC_SLEEP: begin
        if (wakeReq) begin
          cur_nxt.st = CGC_RUN;
        end
      end
      default: cur_nxt.st = CGC_RESET_WAIT;
    endcase
    // registered clock controls, derived from the next state
    cur_nxt.fastEn = (cur_nxt.st != CGC_SLEEP);
    cur_nxt.slowEn = watchdogRun | cur_nxt.speed[CGC_ITMR_EN_BIT];
    cur_nxt.cpuGate = (cur_nxt.st == CGC_RUN) || (cur_nxt.st == CGC_SW_OLD);
    cur_nxt.started = cur_r.started | (cur_nxt.st != CGC_RESET_WAIT);
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cur_r.st <= CGC_RESET_WAIT;
      cur_r.speed <= CGC_SPEED_RST;
      cur_r.freq <= CGC_FREQ_20M;
      cur_r.freqPend <= CGC_FREQ_20M;
      cur_r.per <= CGC_PER_RST;
      cur_r.cnt <= 8'h00;
      cur_r.rdata <= 8'h00;
      cur_r.loaded <= 1'b0;
      cur_r.fastEn <= 1'b0;
      cur_r.slowEn <= 1'b0;
      cur_r.cpuGate <= 1'b0;
      cur_r.started <= 1'b0;
    end else begin
      cur_r <= cur_nxt;
    end
  end

  assign sfrRdata = cur_r.rdata;
  assign fastOscFreqSel = cur_r.freq;
  assign fastOscEnable = cur_r.fastEn;
  assign slowOscEnable = cur_r.slowEn;
  assign itmrClockGate = cur_r.speed[CGC_ITMR_EN_BIT];
  assign cpuClockGate = cur_r.cpuGate;
  assign cpuStarted = cur_r.started;
  assign periphResetN = cur_r.per;
  assign periphWriteEn = cur_r.per;

  property p_itmr_follow;
    @(posedge mclk) disable iff (!rst_n)
      (sfrWrite && sfrAddr == CGC_ADDR_SPEED_CTRL) |=>
        (itmrClockGate == $past(sfrWdata[CGC_ITMR_EN_BIT]));
  endproperty
  a_itmr_follow: assert property (p_itmr_follow) else $error("interval timer gate wrong");
  property p_speed_bits;
    @(posedge mclk) disable iff (!rst_n)
      (sfrRead && sfrAddr == CGC_ADDR_SPEED_CTRL) |=> (sfrRdata[3:0] == 4'h0 && sfrRdata[7:5] == 3'h0);
  endproperty
  a_speed_bits: assert property (p_speed_bits) else $error("speed reserved bits set");
  property p_freq_legal;
    @(posedge mclk) disable iff (!rst_n) cur_r.loaded |-> freqLegal(fastOscFreqSel);
  endproperty
  a_freq_legal: assert property (p_freq_legal) else $error("illegal frequency");
  property p_bad_code;
    @(posedge mclk) disable iff (!rst_n)
      (sfrWrite && sfrAddr == CGC_ADDR_FREQ_SEL && !freqLegal(sfrWdata[2:0])) |=> $stable(cur_r.freqPend);
  endproperty
  a_bad_code: assert property (p_bad_code) else $error("prohibited code taken");
  property p_switch;
    @(posedge mclk) disable iff (!rst_n)
      (cur_r.st == CGC_RUN && cur_nxt.st == CGC_SW_OLD) |=> ##6 (cur_r.st == CGC_RUN);
  endproperty
  a_switch: assert property (p_switch) else $error("switch timing wrong");
  property p_slow;
    @(posedge mclk) disable iff (!rst_n) itmrClockGate |-> slowOscEnable;
  endproperty
  a_slow: assert property (p_slow) else $error("slow osc off with timer gate");
  property p_halt;
    @(posedge mclk) disable iff (!rst_n) (cur_r.st == CGC_RUN && haltReq) |=> cur_r.st == CGC_IDLE;
  endproperty
  a_halt: assert property (p_halt) else $error("halt not taken");
  property p_start;
    @(posedge mclk) disable iff (!rst_n) (cur_r.st == CGC_RESET_WAIT) |-> !cpuClockGate;
  endproperty
  a_start: assert property (p_start) else $error("cpu clock before reset wait");
  property p_optload;
    @(posedge mclk) disable iff (!rst_n)
      (!cur_r.loaded && freqLegal(optionByte[2:0])) |=> fastOscFreqSel == $past(optionByte[2:0]);
  endproperty
  a_optload: assert property (p_optload) else $error("option code not loaded");
  c_switch: cover property (@(posedge mclk) cur_r.st == CGC_SW_NEW);
  c_idle: cover property (@(posedge mclk) cur_r.st == CGC_IDLE);
  c_sleep: cover property (@(posedge mclk) cur_r.st == CGC_SLEEP);
endmodule

/* File: tb_clock_generator_control.sv */
/*
  tb_clock_generator_control: self-checking bench for cgc_clock_ctrl.
  assumes the design holds its own assertions; drives inputs at falling edges.
*/
`timescale 1ns/100ps
module tb_clock_generator_control;
  import cgc_pkg::*;
  logic        mclk = 0, rst_n = 0, sfrWrite = 0, sfrRead = 0;
  logic        haltReq = 0, stopReq = 0, wakeReq = 0, watchdogRun = 0;
  logic [19:0] sfrAddr = '0;
  logic [7:0]  sfrWdata = '0, optionByte = 8'hFB, sfrRdata, periphResetN, periphWriteEn;
  logic [2:0]  fastOscFreqSel;
  logic        fastOscEnable, slowOscEnable, itmrClockGate, cpuClockGate, cpuStarted;
  int          badCount = 0, checkCount = 0, cycles = 0;
  logic [7:0]  rv, n;
  cgc_clock_ctrl i_cgc_clock_ctrl (.mclk(mclk), .rst_n(rst_n), .sfrAddr(sfrAddr),
    .sfrWrite(sfrWrite), .sfrRead(sfrRead), .sfrWdata(sfrWdata), .sfrRdata(sfrRdata),
    .optionByte(optionByte), .haltReq(haltReq), .stopReq(stopReq), .wakeReq(wakeReq),
    .watchdogRun(watchdogRun), .fastOscFreqSel(fastOscFreqSel),
    .fastOscEnable(fastOscEnable), .slowOscEnable(slowOscEnable),
    .itmrClockGate(itmrClockGate), .cpuClockGate(cpuClockGate), .cpuStarted(cpuStarted),
    .periphResetN(periphResetN), .periphWriteEn(periphWriteEn));
  always #5 mclk = ~mclk;
  task automatic stopTest();
    if (badCount == 0 && checkCount > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 3000) begin
      badCount++;
      stopTest();
    end
  end
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checkCount++;
    if (seen !== exp) begin
      badCount++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [19:0] a, input logic [7:0] d);
    @(negedge mclk); sfrAddr = a; sfrWdata = d; sfrWrite = 1;
    @(negedge mclk); sfrWrite = 0;
  endtask
  task automatic rd(input logic [19:0] a, output logic [7:0] d);
    @(negedge mclk); sfrAddr = a; sfrRead = 1;
    @(negedge mclk); d = sfrRdata; sfrRead = 0;
  endtask
  task automatic pulse(input int k);
    @(negedge mclk); haltReq = (k == 0); stopReq = (k == 1); wakeReq = (k == 2);
    @(negedge mclk); haltReq = 0; stopReq = 0; wakeReq = 0;
    repeat (2) @(negedge mclk);
  endtask
  task automatic testReset(input logic [7:0] opt, input logic [7:0] expCode);
    @(negedge mclk); rst_n = 0; optionByte = opt;
    repeat (2) @(negedge mclk);
    chk(8'(cpuStarted), 8'h00);
    rst_n = 1;
    repeat (2) @(negedge mclk);
    chk(8'(fastOscFreqSel), expCode);
    chk(8'(fastOscEnable), 8'h01);
    n = 0;
    while (cpuStarted !== 1'b1 && n < 8'hC8) begin
      @(negedge mclk); n++;
    end
    chk(n, CGC_POR_WAIT_CYCLES - 8'h02);
    rd(CGC_ADDR_SPEED_CTRL, rv); chk(rv, CGC_SPEED_RST);
    rd(CGC_ADDR_FREQ_SEL, rv); chk(rv, expCode);
    rd(CGC_ADDR_OPT_BYTE, rv); chk(rv, {CGC_OPT_HIGH_ONES, opt[2:0]});
  endtask
  task automatic testSpeed();
    wr(CGC_ADDR_SPEED_CTRL, 8'hFF); @(negedge mclk);
    chk(8'(itmrClockGate), 8'h01);
    chk(8'(slowOscEnable), 8'h01);
    rd(CGC_ADDR_SPEED_CTRL, rv); chk(rv, 8'h10);
    wr(CGC_ADDR_SPEED_CTRL, 8'hEF); @(negedge mclk);
    chk(8'(itmrClockGate), 8'h00);
    chk(8'(slowOscEnable), 8'h00);
    watchdogRun = 1; repeat (2) @(negedge mclk);
    chk(8'(slowOscEnable), 8'h01);
    chk(8'(itmrClockGate), 8'h00);
    watchdogRun = 0;
  endtask
  task automatic switchTo(input logic [7:0] code, input logic [7:0] expSel,
                          input logic [7:0] expLow);
    wr(CGC_ADDR_FREQ_SEL, code);
    n = 0;
    repeat (12) begin
      @(negedge mclk); if (cpuClockGate !== 1'b1) n++;
    end
    chk(n, expLow);
    chk(8'(fastOscFreqSel), expSel);
  endtask
  task automatic testFreq();
    for (int c = 1; c <= 5; c++) begin
      switchTo(8'(c), 8'(c), 8'h03);
      rd(CGC_ADDR_FREQ_SEL, rv); chk(rv, 8'(c));
    end
    switchTo(8'h00, 8'h05, 8'h00);
    switchTo(8'h06, 8'h05, 8'h00);
    switchTo(8'h07, 8'h05, 8'h00);
  endtask
  task automatic testPower();
    pulse(0); chk(8'(cpuClockGate), 8'h00);
    chk(8'(fastOscEnable), 8'h01);
    pulse(2); chk(8'(cpuClockGate), 8'h01);
    wr(CGC_ADDR_PER_EN, 8'h00);
    pulse(1); chk(8'(fastOscEnable), 8'h00);
    pulse(2); repeat (4) @(negedge mclk);
    chk(8'(fastOscEnable), 8'h01);
  endtask
  task automatic testPeriph();
    wr(CGC_ADDR_PER_EN, 8'hE5); @(negedge mclk);
    chk(periphResetN, 8'hE5);
    chk(periphWriteEn, 8'hE5);
    wr(CGC_ADDR_PER_EN, 8'h04); @(negedge mclk);
    chk(periphResetN, 8'h04);
    rd(20'h00001, rv); chk(rv, 8'h00);
  endtask
  initial begin
    repeat (2) @(posedge mclk);
    testReset(8'hFB, 8'h03);
    testSpeed();
    testFreq();
    testPeriph();
    testPower();
    wr(CGC_ADDR_SPEED_CTRL, 8'h10);
    testReset(8'hF8, 8'h01);
    stopTest();
  end
endmodule
